// >>> src/lefl_pkg.sv
package lefl_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned ENABLE_DELAY_S = 5;
  localparam int unsigned POWER_OFF_S = 30;
  localparam logic [31:0] ENABLE_DELAY_CYCLES = 32'(ENABLE_DELAY_S * CLK_HZ);
  localparam logic [31:0] POWER_OFF_CYCLES = 32'(POWER_OFF_S * CLK_HZ);
  localparam int unsigned TICKLE_MAX_NS = 3000;
  localparam logic [11:0] TICKLE_MAX_CYCLES = 12'((TICKLE_MAX_NS * (CLK_HZ / 1_000_000)) / 1000);
  localparam logic [11:0] LED_WINDOW_LAST = 12'hFFF;
  localparam logic [7:0] LED_DIM_LEVEL = 8'h10;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] STATUS_OFFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFFS = 8'h08;
  localparam logic [7:0] IRQ_CLR_OFFS = 8'h0C;
  localparam logic [7:0] IRQ_EN_OFFS = 8'h10;
  localparam int unsigned CTRL_OEM_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;
  localparam int unsigned IRQ_NUM = 4;
  localparam int unsigned IRQ_FAULT_BIT = 0;
  localparam int unsigned IRQ_PWR_ON_BIT = 1;
  localparam int unsigned IRQ_PERMIT_BIT = 2;
  localparam int unsigned IRQ_DC_LOST_BIT = 3;

  // ==========================================================
  // Sequencer states
  // ==========================================================
  typedef enum logic [1:0] {
    LEFL_OFF = 2'b00,
    LEFL_DELAY = 2'b01,
    LEFL_READY = 2'b10
  } lefl_state_e;
endpackage : lefl_pkg

// >>> src/lefl_led_drive.sv
`timescale 1ns/1ps
module lefl_led_drive
  import lefl_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  input wire logic pwm_cmd_i,
  output logic [7:0] led_level_o
);
  typedef struct packed {
    logic [11:0] win_cnt;
    logic [11:0] high_cnt;
    logic [11:0] pulse_len;
    logic pulse_seen;
    logic long_seen;
    logic [7:0] level;
  } lefl_led_s;

  lefl_led_s cur_reg;
  lefl_led_s cur_next;

  // ==========================================================
  // Duty measurement over a fixed window
  // ==========================================================
  always_comb begin
    cur_next = cur_reg;
    cur_next.win_cnt = cur_reg.win_cnt + 12'h001;
    if (pwm_cmd_i) begin
      cur_next.high_cnt = cur_reg.high_cnt + 12'h001;
      cur_next.pulse_seen = 1'b1;
      if (cur_reg.pulse_len != 12'hFFF) begin
        cur_next.pulse_len = cur_reg.pulse_len + 12'h001;
      end
      if (cur_reg.pulse_len >= TICKLE_MAX_CYCLES) begin
        cur_next.long_seen = 1'b1;
      end
    end else begin
      cur_next.pulse_len = 12'h000;
    end
    if (cur_reg.win_cnt == LED_WINDOW_LAST) begin
      // Tickle only gives dim; real pulses scale with duty
      if (!enable_i || !cur_next.pulse_seen) begin
        cur_next.level = 8'h00;
      end else if (!cur_next.long_seen || cur_next.high_cnt[11:4] < LED_DIM_LEVEL) begin
        cur_next.level = LED_DIM_LEVEL;
      end else begin
        cur_next.level = cur_next.high_cnt[11:4];
      end
      cur_next.high_cnt = 12'h000;
      cur_next.pulse_seen = 1'b0;
      cur_next.long_seen = 1'b0;
    end
    if (!enable_i) begin
      cur_next.level = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign led_level_o = cur_reg.level;
endmodule : lefl_led_drive

// >>> src/lefl_top.sv
`timescale 1ns/1ps
module lefl_top
  import lefl_pkg::*;
#(
  parameter logic [31:0] DELAY_CYCLES = ENABLE_DELAY_CYCLES,
  parameter logic [31:0] OFF_CYCLES = POWER_OFF_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic dc_power_ok_i,
  input wire logic key_on_i,
  input wire logic remote_key_closed_i,
  input wire logic interlock_closed_i,
  input wire logic shutter_open_i,
  input wire logic over_temp_i,
  input wire logic coolant_ok_i,
  input wire logic hw_fault_i,
  input wire logic pwm_cmd_i,
  output logic power_ok_indicator_o,
  output logic lase_permit_o,
  output logic fault_shutdown_o,
  output logic [7:0] emission_level_o,
  output logic irq_o
);
  typedef struct packed {
    lefl_state_e state;
    logic [31:0] dly_cnt;
    logic [31:0] off_cnt;
    logic off_long;
    logic dc_q;
    logic armed;
    logic ot_lat;
    logic hw_lat;
    logic fo_lat;
    logic permit;
    logic lamp;
    logic fault_ok;
    logic oem;
    logic [IRQ_NUM-1:0] irq_stat;
    logic [IRQ_NUM-1:0] irq_en;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lefl_top_s;

  lefl_top_s cur_reg;
  lefl_top_s cur_next;

  logic key_closed;
  logic cycle_done;
  logic cool_ok;
  logic dc_rise;
  logic dc_fall;
  logic go_on;
  logic blocked;
  logic fault_now;
  logic bus_done;
  logic [IRQ_NUM-1:0] irq_evt;

  // ==========================================================
  // Address decode
  // ==========================================================
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == CTRL_OFFS) || (a == STATUS_OFFS) || (a == IRQ_STAT_OFFS) ||
                  (a == IRQ_CLR_OFFS) || (a == IRQ_EN_OFFS);
  endfunction : addr_mapped

  function automatic logic [31:0] read_mux(input lefl_top_s s, input logic [7:0] a);
    read_mux = 32'h0000_0000;
    case (a)
      CTRL_OFFS: read_mux[CTRL_OEM_BIT] = s.oem;
      STATUS_OFFS: read_mux[10:0] = {s.off_long, s.dc_q, s.armed, s.ot_lat, s.hw_lat,
                                     s.fo_lat, s.permit, (s.state != LEFL_OFF),
                                     s.state == LEFL_READY, s.state};
      IRQ_STAT_OFFS: read_mux[IRQ_NUM-1:0] = s.irq_stat;
      IRQ_EN_OFFS: read_mux[IRQ_NUM-1:0] = s.irq_en;
      default: read_mux = 32'h0000_0000;
    endcase
  endfunction : read_mux

  // ==========================================================
  // Sequencer and register file
  // ==========================================================
  always_comb begin
    cur_next = cur_reg;
    cur_next.dc_q = dc_power_ok_i;
    dc_rise = dc_power_ok_i && !cur_reg.dc_q;
    dc_fall = !dc_power_ok_i && cur_reg.dc_q;
    // OEM builds have no keyswitch; only the remote key counts
    key_closed = cur_reg.oem ? remote_key_closed_i : (key_on_i && remote_key_closed_i);
    cycle_done = cur_reg.armed && key_closed;
    cool_ok = coolant_ok_i && !over_temp_i;
    fault_now = 1'b0;
    go_on = 1'b0;
    irq_evt = '0;

    // Power-off interval timer
    if (!dc_power_ok_i) begin
      if (cur_reg.off_cnt >= OFF_CYCLES - 32'h0000_0001) begin
        cur_next.off_long = 1'b1;
      end else begin
        cur_next.off_cnt = cur_reg.off_cnt + 32'h0000_0001;
      end
    end else begin
      cur_next.off_cnt = 32'h0000_0000;
      cur_next.off_long = 1'b0;
    end

    // Key seen open arms a restart
    if (!key_closed) begin
      cur_next.armed = 1'b1;
    end
    // A key cycle made while still hot does not count
    if (cur_reg.ot_lat && !cool_ok) begin
      cur_next.armed = 1'b0;
    end

    // Clears first; sets below win in the same cycle
    if (dc_rise && cur_reg.off_long && cool_ok) begin
      cur_next.ot_lat = 1'b0;
      cur_next.hw_lat = 1'b0;
      cur_next.fo_lat = 1'b0;
    end
    if (cycle_done && cool_ok && dc_power_ok_i) begin
      cur_next.ot_lat = 1'b0;
      if (!cur_reg.oem) begin
        cur_next.hw_lat = 1'b0;
        cur_next.fo_lat = 1'b0;
      end
    end

    if (dc_power_ok_i && over_temp_i) begin
      cur_next.ot_lat = 1'b1;
      fault_now = 1'b1;
    end
    if (dc_power_ok_i && hw_fault_i) begin
      cur_next.hw_lat = 1'b1;
      fault_now = 1'b1;
    end
    if (cur_reg.state != LEFL_OFF && !interlock_closed_i) begin
      fault_now = 1'b1;
    end
    if (fault_now) begin
      cur_next.fo_lat = 1'b1;
    end

    // Latches as cleared this cycle, so a power-up release can turn on at once
    blocked = cur_next.ot_lat || cur_next.hw_lat;
    case (cur_reg.state)
      LEFL_OFF: begin
        if (dc_power_ok_i && interlock_closed_i && !blocked && !over_temp_i && !hw_fault_i) begin
          if (cur_reg.oem) begin
            go_on = dc_rise || cycle_done;
          end else begin
            go_on = cycle_done;
          end
        end
        if (go_on) begin
          cur_next.state = LEFL_DELAY;
          cur_next.dly_cnt = 32'h0000_0000;
          cur_next.armed = 1'b0;
          irq_evt[IRQ_PWR_ON_BIT] = 1'b1;
        end
      end
      LEFL_DELAY: begin
        if (cur_reg.dly_cnt >= DELAY_CYCLES - 32'h0000_0001) begin
          cur_next.state = LEFL_READY;
        end else begin
          cur_next.dly_cnt = cur_reg.dly_cnt + 32'h0000_0001;
        end
      end
      LEFL_READY: begin
        cur_next.state = LEFL_READY;
      end
      default: begin
        cur_next.state = LEFL_OFF;
      end
    endcase

    // Any shutdown drops back and needs a fresh cycle, except that an OEM build restarts on DC power-up
    if (!dc_power_ok_i || fault_now || (cur_reg.state != LEFL_OFF && !key_closed)) begin
      cur_next.state = LEFL_OFF;
      if (!dc_power_ok_i || fault_now) begin
        cur_next.armed = 1'b0;
      end
    end

    // Shutter is a gate only, never a fault
    cur_next.permit = (cur_next.state == LEFL_READY) && shutter_open_i;
    cur_next.lamp = (cur_next.state != LEFL_OFF);
    cur_next.fault_ok = !cur_next.fo_lat;
    irq_evt[IRQ_PERMIT_BIT] = cur_next.permit && !cur_reg.permit;
    irq_evt[IRQ_FAULT_BIT] = cur_next.fo_lat && !cur_reg.fo_lat;
    irq_evt[IRQ_DC_LOST_BIT] = dc_fall;

    // APB: one wait state, answer registered
    bus_done = psel_i && penable_i && cur_reg.pready;
    cur_next.pready = psel_i && penable_i && !cur_reg.pready;
    cur_next.pslverr = psel_i && penable_i && !cur_reg.pready && !addr_mapped(paddr_i);
    cur_next.prdata = 32'h0000_0000;
    if (psel_i && penable_i && !cur_reg.pready && !pwrite_i) begin
      cur_next.prdata = read_mux(cur_reg, paddr_i);
    end
    if (bus_done && pwrite_i) begin
      case (paddr_i)
        CTRL_OFFS: cur_next.oem = pwdata_i[CTRL_OEM_BIT];
        IRQ_CLR_OFFS: cur_next.irq_stat = cur_reg.irq_stat & ~pwdata_i[IRQ_NUM-1:0];
        IRQ_EN_OFFS: cur_next.irq_en = pwdata_i[IRQ_NUM-1:0];
        default: cur_next.irq_stat = cur_reg.irq_stat;
      endcase
    end
    // Event set wins over a same-cycle clear
    cur_next.irq_stat = cur_next.irq_stat | irq_evt;
    cur_next.irq = |(cur_next.irq_stat & cur_next.irq_en);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_reg <= '0;
      cur_reg.state <= LEFL_OFF;
      cur_reg.oem <= CTRL_RESET;
      cur_reg.irq_en <= IRQ_EN_RESET;
      cur_reg.fault_ok <= 1'b1;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ==========================================================
  // Emission lamp drive
  // ==========================================================
  lefl_led_drive u_led (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .enable_i(cur_reg.permit),
    .pwm_cmd_i(pwm_cmd_i),
    .led_level_o(emission_level_o)
  );

  // ==========================================================
  // Outputs
  // ==========================================================
  assign power_ok_indicator_o = cur_reg.lamp;
  assign lase_permit_o = cur_reg.permit;
  assign fault_shutdown_o = cur_reg.fault_ok;
  assign irq_o = cur_reg.irq;
  assign prdata_o = cur_reg.prdata;
  assign pready_o = cur_reg.pready;
  assign pslverr_o = cur_reg.pslverr;
endmodule : lefl_top

// >>> testbench/lefl_assertions.sv
`timescale 1ns/1ps
module lefl_assertions
  import lefl_pkg::*;
#(
  parameter logic [31:0] DELAY_CYCLES = 32'h14
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic dc_power_ok_i,
  input wire logic key_on_i,
  input wire logic remote_key_closed_i,
  input wire logic interlock_closed_i,
  input wire logic shutter_open_i,
  input wire logic over_temp_i,
  input wire logic hw_fault_i,
  input wire logic power_ok_indicator_o,
  input wire logic lase_permit_o,
  input wire logic fault_shutdown_o
);
  // ==========
  // Lamp-on age
  logic [31:0] on_cnt;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) on_cnt <= 32'h0;
    else if (!power_ok_indicator_o) on_cnt <= 32'h0;
    else if (on_cnt != 32'hFFFFFFFF) on_cnt <= on_cnt + 32'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence acc_start;
    psel_i && penable_i && !$past(penable_i);
  endsequence
  sequence switches_steady;
    (key_on_i && remote_key_closed_i && dc_power_ok_i)[*4];
  endsequence
  a_pready_wait: assert property (acc_start |-> !pready_o ##1 pready_o)
    else $error("pready not in second access cycle");
  a_pready_once: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_lamp_dc: assert property (!dc_power_ok_i |-> ##[1:2] !power_ok_indicator_o)
    else $error("lamp on without dc");
  a_lamp_ilk: assert property (!interlock_closed_i |-> ##[1:2] !power_ok_indicator_o)
    else $error("lamp on with interlock open");
  a_lamp_key: assert property (!remote_key_closed_i |-> ##[1:2] !power_ok_indicator_o)
    else $error("lamp on with key open");
  a_shut_gate: assert property (!shutter_open_i |-> ##[1:2] !lase_permit_o)
    else $error("permit with shutter closed");
  a_fault_on: assert property ((over_temp_i || hw_fault_i) |-> ##[1:2] !fault_shutdown_o)
    else $error("fault output not dropped");
  a_fault_hold: assert property (switches_steady ##0 !fault_shutdown_o |=> !fault_shutdown_o)
    else $error("fault output released without reset");
  a_permit_early: assert property (lase_permit_o && power_ok_indicator_o
    |-> on_cnt >= DELAY_CYCLES)
    else $error("permit before enable delay");
  a_permit_due: assert property (power_ok_indicator_o && shutter_open_i && $past(shutter_open_i)
    && on_cnt == DELAY_CYCLES + 32'h3 |-> lase_permit_o)
    else $error("permit late after enable delay");
endmodule : lefl_assertions

// >>> testbench/lefl_partner.sv
`timescale 1ns/1ps
module lefl_partner (
  input wire logic clk_i,
  input wire logic cyc_key_i,
  input wire logic cyc_rem_i,
  input wire logic [7:0] duty_i,
  output logic key_on_o,
  output logic remote_key_closed_o,
  output logic pwm_cmd_o
);
  logic [2:0] key_cnt = 3'h0;
  logic [2:0] rem_cnt = 3'h0;
  logic [7:0] phase = 8'h00;
  // Switch held open five cycles, then closed
  always @(posedge clk_i) begin
    if (cyc_key_i) key_cnt <= 3'h5;
    else if (key_cnt != 3'h0) key_cnt <= key_cnt - 3'h1;
    if (cyc_rem_i) rem_cnt <= 3'h5;
    else if (rem_cnt != 3'h0) rem_cnt <= rem_cnt - 3'h1;
    phase <= phase + 8'h1;
  end
  assign key_on_o = (key_cnt == 3'h0);
  assign remote_key_closed_o = (rem_cnt == 3'h0);
  // Pulse of duty_i cycles every 256
  assign pwm_cmd_o = (phase < duty_i);
endmodule : lefl_partner

// >>> testbench/lefl_top_tb.sv
`timescale 1ns/1ps
module lefl_top_tb
  import lefl_pkg::*;
;
  localparam int DLY = 20;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic dc_power_ok_i = 1'b1, interlock_closed_i = 1'b1, shutter_open_i = 1'b0;
  logic over_temp_i = 1'b0, coolant_ok_i = 1'b1, hw_fault_i = 1'b0;
  logic key_on_i, remote_key_closed_i, pwm_cmd_i, pready_o, pslverr_o, irq_o;
  logic power_ok_indicator_o, lase_permit_o, fault_shutdown_o;
  logic [31:0] prdata_o, rd;
  logic [7:0] emission_level_o, duty = 8'h00;
  logic cyc_key = 1'b0, cyc_rem = 1'b0, er;
  int mismatches = 0, checked = 0, d;
  always #50 clk_i = ~clk_i;
  lefl_top #(.DELAY_CYCLES(32'h14), .OFF_CYCLES(32'h1E)) lefl_top_inst (.*);
  lefl_partner lefl_partner_inst (.clk_i(clk_i), .cyc_key_i(cyc_key), .cyc_rem_i(cyc_rem),
    .duty_i(duty), .key_on_o(key_on_i), .remote_key_closed_o(remote_key_closed_i),
    .pwm_cmd_o(pwm_cmd_i));
  // ==========
  // Helpers
  function automatic logic [7:0] exp_level(input logic [7:0] dt);
    return (dt > TICKLE_MAX_CYCLES) ? dt : LED_DIM_LEVEL;
  endfunction : exp_level
  task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_w
  task automatic chk_b(input string nm, input logic e, input logic g);
    chk_w(nm, {31'h0, e}, {31'h0, g});
  endtask : chk_b
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) mismatches++;
  endtask : apb
  task automatic swcyc(input logic rem);
    if (rem) cyc_rem <= 1'b1;
    else cyc_key <= 1'b1;
    @(posedge clk_i);
    cyc_key <= 1'b0;
    cyc_rem <= 1'b0;
    cyc(8);
  endtask : swcyc
  task automatic power_ok_indicator(input int n);
    dc_power_ok_i <= 1'b0;
    cyc(n);
    dc_power_ok_i <= 1'b1;
    cyc(5);
  endtask : power_ok_indicator
  task automatic heat;
    over_temp_i <= 1'b1;
    coolant_ok_i <= 1'b0;
    cyc(3);
    over_temp_i <= 1'b0;
    coolant_ok_i <= 1'b1;
  endtask : heat
  task automatic give_verdict;
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // ==========
  // Tests
  initial begin
    d = $urandom(54);
    cyc(16);
    resetn_i <= 1'b1;
    apb(1'b0, CTRL_OFFS, 32'h0);
    chk_w("ctrl", {31'h0, CTRL_RESET}, rd);
    apb(1'b1, IRQ_EN_OFFS, 32'h1);
    apb(1'b0, IRQ_EN_OFFS, 32'h0);
    chk_w("irq_en", 32'h1, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk_b("slverr", 1'b1, er);
    chk_b("lamp", 1'b0, power_ok_indicator_o);
    swcyc(1'b0);
    chk_b("lamp", 1'b1, power_ok_indicator_o);
    cyc(DLY + 4);
    chk_b("permit", 1'b0, lase_permit_o);
    shutter_open_i <= 1'b1;
    cyc(3);
    chk_b("permit", 1'b1, lase_permit_o);
    apb(1'b0, STATUS_OFFS, 32'h0);
    chk_w("status", 32'h0000_021E, rd);
    $display("Test power-on done");
    duty <= 8'h02;
    cyc(8200);
    chk_w("emission", {24'h0, exp_level(8'h02)}, {24'h0, emission_level_o});
    duty <= 8'(TICKLE_MAX_CYCLES + 12'h001);
    cyc(8200);
    chk_w("emission", {24'h0, exp_level(8'(TICKLE_MAX_CYCLES + 12'h001))},
          {24'h0, emission_level_o});
    d = 64 + ($urandom % 128);
    duty <= 8'(d);
    cyc(8200);
    chk_w("emission", {24'h0, exp_level(8'(d))}, {24'h0, emission_level_o});
    $display("Test emission done");
    heat();
    chk_b("irq", 1'b1, irq_o);
    cyc(10);
    chk_b("fault", 1'b0, fault_shutdown_o);
    chk_b("lamp", 1'b0, power_ok_indicator_o);
    chk_w("emission", 32'h0, {24'h0, emission_level_o});
    apb(1'b1, IRQ_CLR_OFFS, 32'h1);
    apb(1'b0, IRQ_STAT_OFFS, 32'h0);
    chk_b("irq_stat", 1'b0, rd[IRQ_FAULT_BIT]);
    chk_b("irq", 1'b0, irq_o);
    swcyc(1'b0);
    chk_b("fault", 1'b1, fault_shutdown_o);
    chk_b("permit", 1'b0, lase_permit_o);
    cyc(DLY);
    chk_b("permit", 1'b1, lase_permit_o);
    $display("Test over-temp done");
    apb(1'b1, IRQ_EN_OFFS, 32'h0);
    interlock_closed_i <= 1'b0;
    cyc(3);
    interlock_closed_i <= 1'b1;
    cyc(10);
    chk_b("lamp", 1'b0, power_ok_indicator_o);
    chk_b("fault", 1'b0, fault_shutdown_o);
    chk_b("irq", 1'b0, irq_o);
    swcyc(1'b1);
    chk_b("lamp", 1'b1, power_ok_indicator_o);
    hw_fault_i <= 1'b1;
    cyc(2);
    hw_fault_i <= 1'b0;
    power_ok_indicator(40);
    chk_b("fault", 1'b1, fault_shutdown_o);
    chk_b("lamp", 1'b0, power_ok_indicator_o);
    $display("Test keyswitch done");
    apb(1'b1, CTRL_OFFS, 32'h1);
    heat();
    swcyc(1'b1);
    chk_b("lamp", 1'b1, power_ok_indicator_o);
    // Equipment-side restart lockout: shutter held closed over power loss
    shutter_open_i <= 1'b0;
    power_ok_indicator(10);
    chk_b("fault", 1'b0, fault_shutdown_o);
    power_ok_indicator(40);
    chk_b("fault", 1'b1, fault_shutdown_o);
    chk_b("lamp", 1'b1, power_ok_indicator_o);
    chk_b("permit", 1'b0, lase_permit_o);
    $display("Test oem done");
    give_verdict();
  end
  initial begin
    cyc(40000);
    mismatches++;
    give_verdict();
  end
endmodule : lefl_top_tb
bind lefl_top lefl_assertions #(.DELAY_CYCLES(DELAY_CYCLES)) lefl_assertions_inst (.*);
